// File: double_precision_shifter.sv
// Purpose: execution datapath for the funnel shift left and right instructions
// Assumes: the decoder presents one request per req_valid cycle with segment checks resolved
// Notes: answers one cycle after the request; AXI4-Lite slave for control and status
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module double_precision_shifter #(
  parameter int ADDR_W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire dps_pkg::req_type req,
  input wire dps_pkg::mem_check_type mem_chk,
  output logic done,
  output dps_pkg::answer_type answer,
  output dps_pkg::fault_type fault,
  output logic undefined_count,
  output logic bad_opcode,
  output logic irq,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp
);
  typedef struct packed {
    dps_pkg::bus_state_type bus;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic zero_fill;
    logic [dps_pkg::N_EVENTS-1:0] status;
    logic [dps_pkg::N_EVENTS-1:0] mask;
    logic irq;
    logic done;
    logic undefined_count;
    logic bad_opcode;
    dps_pkg::answer_type answer;
    dps_pkg::fault_type fault;
    logic [31:0] last_result;
    dps_pkg::flags_type last_flags;
    dps_pkg::fault_kind_type last_fault;
  } state_type;

  state_type state;
  state_type next_state;

  logic known;
  logic left;
  logic use_imm;
  logic [7:0] count_raw;
  logic [4:0] count;
  logic [5:0] size;
  logic over_size;
  logic [31:0] shifted;
  logic carry;
  logic [31:0] res;
  dps_pkg::fault_type chk_fault;
  logic [dps_pkg::N_EVENTS-1:0] events;
  logic [dps_pkg::N_EVENTS-1:0] w1c;
  logic [7:0] waddr;
  logic [7:0] raddr;

  // shift core sees the masked count directly
  funnel_core u_core (
    .dest(req.dest),
    .src(req.src),
    .count(count),
    .size32(req.size32),
    .left(left),
    .result(shifted),
    .carry(carry)
  );

  // faults only for a memory destination
  fault_check u_fault (
    .chk(mem_chk),
    .dest_is_mem(req.dest_is_mem),
    .size32(req.size32),
    .fault(chk_fault)
  );

  always_comb begin
    known = 1'b0;
    left = 1'b0;
    use_imm = 1'b0;
    if (req.prefix == dps_pkg::OP_PREFIX) begin
      case (req.opcode)
        dps_pkg::OP_LEFT_IMM: begin
          known = 1'b1;
          left = 1'b1;
          use_imm = 1'b1;
        end
        dps_pkg::OP_LEFT_CNT: begin
          known = 1'b1;
          left = 1'b1;
        end
        dps_pkg::OP_RIGHT_IMM: begin
          known = 1'b1;
          use_imm = 1'b1;
        end
        dps_pkg::OP_RIGHT_CNT: begin
          known = 1'b1;
        end
        default: begin
          known = 1'b0;
        end
      endcase
    end
  end

  assign count_raw = use_imm ? req.immediate_count_byte : req.count_register_low_byte;
  assign count = count_raw[4:0];
  assign size = req.size32 ? dps_pkg::SIZE_32 : dps_pkg::SIZE_16;
  // out-of-range count, only reachable at 16 bits
  assign over_size = {1'b0, count} >= size;
  // zero-fill mode trades the natural funnel value for a clean zero on an out-of-range count
  assign res = (over_size && state.zero_fill) ? 32'h0 : shifted;

  // bus addresses held stable by the master until taken
  assign waddr = 8'(awaddr);
  assign raddr = 8'(araddr);

  // next-state logic for datapath, event flags and bus slave
  always_comb begin
    next_state = state;
    events = '0;
    w1c = '0;

    // answer defaults: destination passed through, nothing written
    next_state.done = req_valid;
    next_state.undefined_count = 1'b0;
    next_state.bad_opcode = req_valid && !known;
    next_state.answer.result = req.dest;
    next_state.answer.result_we = 1'b0;
    next_state.answer.flags_we = 1'b0;
    next_state.answer.flags = '0;
    next_state.fault.kind = dps_pkg::FAULT_NONE;
    next_state.fault.code = 32'h0;

    if (req_valid && known) begin
      next_state.fault = chk_fault;
      if (chk_fault.kind != dps_pkg::FAULT_NONE) begin
        events[dps_pkg::EV_FAULT_BIT] = 1'b1;
      // zero count: no write, no flag update
      end else if (count != 5'h0) begin
        next_state.answer.result = res;
        next_state.answer.result_we = 1'b1;
        next_state.answer.flags_we = 1'b1;
        // last bit out; forced low for an out-of-range count in zero-fill mode
        next_state.answer.flags.carry_flag = carry && !(over_size && state.zero_fill);
        // top-bit change, also used above one
        next_state.answer.flags.overflow_flag =
          dps_pkg::top_bit(res, req.size32) ^ dps_pkg::top_bit(req.dest, req.size32);
        next_state.answer.flags.sign_flag = dps_pkg::top_bit(res, req.size32);
        next_state.answer.flags.zero_flag = (res == 32'h0);
        next_state.answer.flags.parity_flag = ~^res[7:0];
        // auxiliary carry held low for repeatability
        next_state.answer.flags.auxiliary_carry_flag = 1'b0;
        next_state.undefined_count = over_size;
        events[dps_pkg::EV_BADCNT_BIT] = over_size;
      end
      events[dps_pkg::EV_DONE_BIT] = (chk_fault.kind == dps_pkg::FAULT_NONE);
      next_state.last_result = next_state.answer.result;
      next_state.last_flags = next_state.answer.flags;
      next_state.last_fault = chk_fault.kind;
    end
    events[dps_pkg::EV_BADOP_BIT] = req_valid && !known;

    // bus slave: one transfer at a time, write before read
    case (state.bus)
      dps_pkg::BUS_IDLE: begin
        if (awvalid && wvalid) begin
          next_state.awready = 1'b1;
          next_state.wready = 1'b1;
          next_state.bus = dps_pkg::BUS_WACC;
        end else if (arvalid) begin
          next_state.arready = 1'b1;
          next_state.bus = dps_pkg::BUS_RACC;
        end
      end
      dps_pkg::BUS_WACC: begin
        // address and data taken at this edge
        next_state.awready = 1'b0;
        next_state.wready = 1'b0;
        next_state.bvalid = 1'b1;
        next_state.bresp = dps_pkg::RESP_OKAY;
        next_state.bus = dps_pkg::BUS_WRESP;
        case (waddr)
          dps_pkg::ADDR_CTRL: begin
            if (wstrb[0]) begin
              next_state.zero_fill = wdata[dps_pkg::CTRL_ZERO_FILL_BIT];
            end
          end
          dps_pkg::ADDR_STATUS: begin
            if (wstrb[0]) begin
              w1c = wdata[dps_pkg::N_EVENTS-1:0];
            end
          end
          dps_pkg::ADDR_MASK: begin
            if (wstrb[0]) begin
              next_state.mask = wdata[dps_pkg::N_EVENTS-1:0];
            end
          end
          dps_pkg::ADDR_RESULT, dps_pkg::ADDR_FLAGS: begin
            // read-only: write ignored
            next_state.bresp = dps_pkg::RESP_OKAY;
          end
          default: begin
            next_state.bresp = dps_pkg::RESP_SLVERR;
          end
        endcase
      end
      dps_pkg::BUS_WRESP: begin
        if (bready) begin
          next_state.bvalid = 1'b0;
          next_state.bus = dps_pkg::BUS_IDLE;
        end
      end
      dps_pkg::BUS_RACC: begin
        next_state.arready = 1'b0;
        next_state.rvalid = 1'b1;
        next_state.rresp = dps_pkg::RESP_OKAY;
        next_state.rdata = 32'h0;
        next_state.bus = dps_pkg::BUS_RDATA;
        case (raddr)
          dps_pkg::ADDR_CTRL: begin
            next_state.rdata[dps_pkg::CTRL_ZERO_FILL_BIT] = state.zero_fill;
          end
          dps_pkg::ADDR_STATUS: begin
            next_state.rdata[dps_pkg::N_EVENTS-1:0] = state.status;
          end
          dps_pkg::ADDR_MASK: begin
            next_state.rdata[dps_pkg::N_EVENTS-1:0] = state.mask;
          end
          dps_pkg::ADDR_RESULT: begin
            next_state.rdata = state.last_result;
          end
          dps_pkg::ADDR_FLAGS: begin
            next_state.rdata[5:0] = state.last_flags;
            next_state.rdata[dps_pkg::FLAGS_FAULT_LSB +: 3] = state.last_fault;
          end
          default: begin
            next_state.rresp = dps_pkg::RESP_SLVERR;
          end
        endcase
      end
      dps_pkg::BUS_RDATA: begin
        if (rready) begin
          next_state.rvalid = 1'b0;
          next_state.bus = dps_pkg::BUS_IDLE;
        end
      end
      default: begin
        next_state.bus = dps_pkg::BUS_IDLE;
      end
    endcase

    // sticky events: a new event beats a same-cycle clear
    next_state.status = (state.status & ~w1c) | events;
    next_state.irq = |(next_state.status & next_state.mask);

    // synchronous reset
    if (!rst_b) begin
      next_state = '0;
      next_state.bus = dps_pkg::BUS_IDLE;
      next_state.zero_fill = dps_pkg::CTRL_ZERO_FILL_RESET;
      next_state.mask = dps_pkg::MASK_RESET;
    end
  end

  // single state register
  always_ff @(posedge clk) begin
    state <= next_state;
  end

  // every output straight from the state register
  assign done = state.done;
  assign answer = state.answer;
  assign fault = state.fault;
  assign undefined_count = state.undefined_count;
  assign bad_opcode = state.bad_opcode;
  assign irq = state.irq;
  assign awready = state.awready;
  assign wready = state.wready;
  assign bvalid = state.bvalid;
  assign bresp = state.bresp;
  assign arready = state.arready;
  assign rvalid = state.rvalid;
  assign rdata = state.rdata;
  assign rresp = state.rresp;
endmodule // double_precision_shifter
`default_nettype wire

// File: double_precision_shifter_properties.sv
// Purpose: concurrent checks on the shifter datapath ports
// Assumes: one clock, synchronous active-low reset
// Notes: the answer is compared with the request captured one edge earlier
`timescale 1ns/1ns
`default_nettype none
module double_precision_shifter_properties (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire dps_pkg::req_type req,
  input wire dps_pkg::mem_check_type mem_chk,
  input wire logic done,
  input wire dps_pkg::answer_type answer,
  input wire dps_pkg::fault_type fault,
  input wire logic undefined_count,
  input wire logic bad_opcode
);
  logic [4:0] cnt;
  logic [4:0] last_cnt;
  logic known;
  logic reg32;
  logic gp;
  logic plain;
  dps_pkg::req_type last;
  dps_pkg::mem_check_type lastc;
  // masked count and decode as the datapath should see them
  assign cnt = req.opcode[0] ? req.count_register_low_byte[4:0] : req.immediate_count_byte[4:0];
  assign known = req.prefix == dps_pkg::OP_PREFIX && (req.opcode == dps_pkg::OP_LEFT_IMM ||
    req.opcode == dps_pkg::OP_LEFT_CNT || req.opcode == dps_pkg::OP_RIGHT_IMM || req.opcode == dps_pkg::OP_RIGHT_CNT);
  assign reg32 = known && req.size32 && !req.dest_is_mem;
  // protection fault causes, used to isolate the lower priority faults
  assign gp = mem_chk.over_limit || (mem_chk.protected_mode && (mem_chk.null_selector || !mem_chk.seg_writable));
  assign plain = known && req.dest_is_mem && !gp && !mem_chk.over_stack_limit;
  // capture the request each answer belongs to
  always_ff @(posedge clk) begin
    last <= req;
    lastc <= mem_chk;
    last_cnt <= cnt;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_take(c);
    req_valid && c;
  endsequence
  sequence s_answer;
    done && answer.result_we && answer.flags_we;
  endsequence
  chk_decode_known: assert property (s_take(known) |=> done && !bad_opcode)
    else $error("known opcode not answered");
  chk_bad_opcode: assert property (s_take(!known) |=> bad_opcode && !answer.result_we && !answer.flags_we)
    else $error("unknown opcode changed state");
  chk_zero_count: assert property (s_take(known && cnt == 5'h00 && !req.dest_is_mem) |=>
    !answer.result_we && !answer.flags_we && answer.result == last.dest) else $error("zero count changed state");
  chk_left_funnel: assert property (s_take(reg32 && !req.opcode[3] && cnt != 5'h00) |=> s_answer ##0
    answer.result == ((last.dest << last_cnt) | (last.src >> (6'h20 - last_cnt))) &&
    answer.flags.carry_flag == last.dest[6'h20 - last_cnt]) else $error("left funnel wrong");
  chk_right_funnel: assert property (s_take(reg32 && req.opcode[3] && cnt != 5'h00) |=> s_answer ##0
    answer.result == ((last.dest >> last_cnt) | (last.src << (6'h20 - last_cnt))) &&
    answer.flags.carry_flag == last.dest[last_cnt - 5'h01]) else $error("right funnel wrong");
  chk_one_bit_ov: assert property (s_take(reg32 && cnt == 5'h01) |=>
    answer.flags.overflow_flag == (answer.result[31] ^ last.dest[31])) else $error("overflow wrong");
  chk_result_flags: assert property (s_take(reg32 && cnt != 5'h00) |=> answer.flags.zero_flag == (answer.result == 0) &&
    answer.flags.sign_flag == answer.result[31] && answer.flags.parity_flag == ~^answer.result[7:0])
    else $error("result flags wrong");
  chk_high_count: assert property (s_take(known && !req.size32 && !req.dest_is_mem && cnt[4]) |=> undefined_count)
    else $error("count past size not flagged");
  chk_gp_protect: assert property (s_take(known && req.dest_is_mem && mem_chk.protected_mode &&
    !mem_chk.seg_writable) |=> fault.kind == dps_pkg::FAULT_GP && !answer.result_we)
    else $error("write protect fault missing");
  chk_page_fault: assert property (s_take(plain && mem_chk.page_fail) |=>
    fault.kind == dps_pkg::FAULT_PF && fault.code == lastc.page_code) else $error("page fault wrong");
  chk_align_user: assert property (s_take(plain && !mem_chk.page_fail && mem_chk.align_enable && req.size32 &&
    mem_chk.ea_low != 2'h0) |=> fault.kind == (lastc.cpl == dps_pkg::CPL_USER ? dps_pkg::FAULT_AC : dps_pkg::FAULT_NONE))
    else $error("alignment fault wrong");
endmodule // double_precision_shifter_properties
`default_nettype wire

// File: double_precision_shifter_tb_top.sv
// Purpose: self-checking bench for the shifter datapath and its registers
// Assumes: answers come one cycle after a request, AXI readies as handed over
// Notes: counts at or past the operand size are checked for their undefined_count pulse, and for the whole answer only in zero-fill mode
`timescale 1ns/1ns
`default_nettype none
module double_precision_shifter_tb_top;
  logic clk, rst_b, go, req_valid, done, undefined_count, bad_opcode, irq;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  dps_pkg::req_type req_in, req;
  dps_pkg::mem_check_type chk_in, mem_chk;
  dps_pkg::answer_type answer;
  dps_pkg::fault_type fault;
  int failures, total_checks;
  logic [7:0] ops [4] = '{8'hA4, 8'hA5, 8'hAC, 8'hAD};
  logic [7:0] corner [6] = '{8'h00, 8'h01, 8'h0F, 8'h10, 8'h1F, 8'hE1};
  logic [7:0] fpat [8] = '{8'h80, 8'h60, 8'hD0, 8'h48, 8'h44, 8'h43, 8'h42, 8'h10};
  logic [2:0] fexp [8] = '{3'h1, 3'h1, 3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0};
  always #50 clk = ~clk;
  dps_decoder_model dps_decoder_model_i (.clk(clk), .rst_b(rst_b), .go(go), .req_in(req_in), .chk_in(chk_in),
    .req_valid(req_valid), .req(req), .mem_chk(mem_chk));
  double_precision_shifter double_precision_shifter_i (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .mem_chk(mem_chk), .done(done), .answer(answer), .fault(fault), .undefined_count(undefined_count),
    .bad_opcode(bad_opcode), .irq(irq), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));
  task automatic chk(input string what, input logic [63:0] e, input logic [63:0] s);
    total_checks++;
    if (e !== s) begin
      failures++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // both channels offered together; the slave raises both readies in one cycle
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    awvalid <= 1'h1;
    awaddr <= a;
    wvalid <= 1'h1;
    wdata <= d;
    bready <= 1'h1;
    do @(posedge clk); while (awready !== 1'h1);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    do @(posedge clk); while (bvalid !== 1'h1);
    r = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    arvalid <= 1'h1;
    araddr <= a;
    rready <= 1'h1;
    do @(posedge clk); while (arready !== 1'h1);
    arvalid <= 1'h0;
    do @(posedge clk); while (rvalid !== 1'h1);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask
  // the model needs one edge to launch, the answer settles by a falling edge
  task automatic issue(input dps_pkg::req_type r, input dps_pkg::mem_check_type c);
    @(posedge clk);
    go <= 1'h1;
    req_in <= r;
    chk_in <= c;
    @(posedge clk);
    go <= 1'h0;
    do @(negedge clk); while (done !== 1'h1);
  endtask
  // expected answer, top bit set when the count is at or past the operand size
  function automatic logic [40:0] calc(input dps_pkg::req_type r);
    logic [4:0] n;
    logic [5:0] sz;
    logic [63:0] w;
    dps_pkg::answer_type a;
    n = r.opcode[0] ? r.count_register_low_byte[4:0] : r.immediate_count_byte[4:0];
    sz = r.size32 ? dps_pkg::SIZE_32 : dps_pkg::SIZE_16;
    a = '0;
    a.result = r.dest;
    if (n == 5'h00) return {1'h0, a};
    if (r.size32) w = r.opcode[3] ? {r.src, r.dest} >> n : {r.dest, r.src} << n;
    else w = r.opcode[3] ? {32'h0, r.src[15:0], r.dest[15:0]} >> n : {r.dest[15:0], r.src[15:0], 32'h0} << n;
    if (r.opcode[3]) a.result = r.size32 ? w[31:0] : {16'h0, w[15:0]};
    else a.result = r.size32 ? w[63:32] : {16'h0, w[63:48]};
    a.result_we = 1'h1;
    a.flags_we = 1'h1;
    a.flags.carry_flag = r.opcode[3] ? r.dest[n - 5'h01] : r.dest[sz - n];
    a.flags.parity_flag = ~^a.result[7:0];
    a.flags.zero_flag = a.result == 32'h0;
    a.flags.sign_flag = r.size32 ? a.result[31] : a.result[15];
    a.flags.overflow_flag = a.flags.sign_flag ^ (r.size32 ? r.dest[31] : r.dest[15]);
    return {n >= sz, a};
  endfunction
  initial begin
    dps_pkg::req_type r;
    dps_pkg::mem_check_type c;
    logic [40:0] e;
    logic [31:0] d;
    logic [1:0] rs;
    logic [7:0] p;
    {clk, rst_b, go, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, req_in, chk_in} = '0;
    wstrb = 4'hF;
    d = $urandom(32'hB9424FC7);
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    // reset values and an unmapped place
    axi_rd(dps_pkg::ADDR_CTRL, d, rs);
    chk("ctrl", 64'h0, 64'({rs, d}));
    axi_rd(dps_pkg::ADDR_MASK, d, rs);
    chk("mask", 64'h0, 64'({rs, d}));
    axi_rd(8'h40, d, rs);
    chk("unmapped read", 64'(rs), 64'(dps_pkg::RESP_SLVERR));
    axi_wr(8'h44, 32'h1, rs);
    chk("unmapped write", 64'(rs), 64'(dps_pkg::RESP_SLVERR));
    $display("test reset_regs done");
    c = '0;
    c.seg_writable = 1'h1;
    for (int i = 0; i < 64; i++) begin
      r = '0;
      r.prefix = dps_pkg::OP_PREFIX;
      r.opcode = ops[i % 4];
      r.size32 = (i < 12) ? i[2] : 1'($urandom);
      r.immediate_count_byte = (i < 12) ? corner[i % 6] : 8'($urandom);
      r.count_register_low_byte = (i < 12) ? corner[i % 6] : 8'($urandom);
      r.dest = $urandom;
      r.src = $urandom;
      issue(r, c);
      e = calc(r);
      if (e[40]) chk("undefined_count", 64'h1, 64'(undefined_count));
      else chk("answer", 64'(e[39:0]), 64'(answer));
    end
    $display("test funnel done");
    r.opcode = dps_pkg::OP_LEFT_IMM;
    r.immediate_count_byte = 8'h01;
    r.size32 = 1'h1;
    r.dest_is_mem = 1'h1;
    for (int k = 0; k < 8; k++) begin
      p = fpat[k];
      c = '0;
      {c.protected_mode, c.seg_writable, c.over_limit, c.null_selector} = p[7:4];
      {c.over_stack_limit, c.page_fail, c.align_enable} = p[3:1];
      c.cpl = p[0] ? dps_pkg::CPL_USER : 2'h2;
      c.ea_low = 2'h1;
      c.page_code = $urandom;
      issue(r, c);
      chk("fault", 64'({fexp[k], (fexp[k] == 3'h3) ? c.page_code : 32'h0}), 64'(fault));
      chk("result_we", 64'(fexp[k] == 3'h0), 64'(answer.result_we));
    end
    // last clean answer is readable over the bus
    e = calc(r);
    axi_rd(dps_pkg::ADDR_RESULT, d, rs);
    chk("result reg", 64'(e[39:8]), 64'(d));
    axi_rd(dps_pkg::ADDR_FLAGS, d, rs);
    chk("flags reg", 64'(e[5:0]), 64'(d));
    $display("test faults done");
    r.prefix = 8'h0E;
    issue(r, c);
    chk("bad_opcode", 64'h1, 64'(bad_opcode));
    // sticky events, mask, write-one clear
    axi_rd(dps_pkg::ADDR_STATUS, d, rs);
    chk("status", 64'hF, 64'(d));
    chk("irq masked", 64'h0, 64'(irq));
    axi_wr(dps_pkg::ADDR_MASK, 32'h8, rs);
    repeat (2) @(negedge clk);
    chk("irq raised", 64'h1, 64'(irq));
    axi_wr(dps_pkg::ADDR_STATUS, 32'h8, rs);
    repeat (2) @(negedge clk);
    chk("irq cleared", 64'h0, 64'(irq));
    axi_rd(dps_pkg::ADDR_STATUS, d, rs);
    chk("status cleared", 64'h7, 64'(d));
    $display("test events done");
    // zero-fill mode: count past a 16-bit size gives a clean zero
    axi_wr(dps_pkg::ADDR_CTRL, 32'h1, rs);
    r.prefix = dps_pkg::OP_PREFIX;
    r.size32 = 1'h0;
    r.dest_is_mem = 1'h0;
    r.immediate_count_byte = 8'h13;
    issue(r, c);
    chk("zero fill", 64'({32'h0, 2'h3, 5'h0A, r.dest[15]}), 64'(answer));
    $display("test zero_fill done");
    finish_test();
  end
  // whole run is near three hundred cycles; twenty thousand means a hang
  initial begin
    #(100 * 20000);
    failures++;
    finish_test();
  end
endmodule // double_precision_shifter_tb_top
bind double_precision_shifter double_precision_shifter_properties double_precision_shifter_properties_i (
  .clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req), .mem_chk(mem_chk), .done(done), .answer(answer),
  .fault(fault), .undefined_count(undefined_count), .bad_opcode(bad_opcode));
`default_nettype wire

// File: dps_decoder_model.sv
// Purpose: stand-in for the decoder issuing one request per go pulse
// Assumes: go and the request fields change just after a rising edge
// Notes: idle cycles scramble the request lines so stale data is never trusted
`timescale 1ns/1ns
`default_nettype none
module dps_decoder_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire dps_pkg::req_type req_in,
  input wire dps_pkg::mem_check_type chk_in,
  output logic req_valid,
  output dps_pkg::req_type req,
  output dps_pkg::mem_check_type mem_chk
);
  // count as raw bytes, fill bits from a register value only
  // issue on go; idle lines invert each cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      req_valid <= 1'h0;
      req <= '0;
      mem_chk <= '0;
    end else begin
      req_valid <= go;
      req <= go ? req_in : ~req;
      mem_chk <= go ? chk_in : ~mem_chk;
    end
  end
endmodule // dps_decoder_model
`default_nettype wire

// File: dps_pkg.sv
// Purpose: shared constants and carrier types of the double-precision shifter
// Assumes: one core clock, synchronous active-low reset
// Notes: register offsets are byte addresses on a 32-bit AXI4-Lite slave
`default_nettype none
package dps_pkg;
  // opcode bytes
  localparam logic [7:0] OP_PREFIX = 8'h0F;
  localparam logic [7:0] OP_LEFT_IMM = 8'hA4;
  localparam logic [7:0] OP_LEFT_CNT = 8'hA5;
  localparam logic [7:0] OP_RIGHT_IMM = 8'hAC;
  localparam logic [7:0] OP_RIGHT_CNT = 8'hAD;
  // operand sizes in bits
  localparam logic [5:0] SIZE_16 = 6'h10;
  localparam logic [5:0] SIZE_32 = 6'h20;
  localparam logic [1:0] CPL_USER = 2'h3;
  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_RESULT = 8'h0C;
  localparam logic [7:0] ADDR_FLAGS = 8'h10;
  localparam int CTRL_ZERO_FILL_BIT = 0;
  localparam int FLAGS_FAULT_LSB = 8;
  localparam int EV_DONE_BIT = 0;
  localparam int EV_FAULT_BIT = 1;
  localparam int EV_BADCNT_BIT = 2;
  localparam int EV_BADOP_BIT = 3;
  localparam int N_EVENTS = 4;
  localparam logic CTRL_ZERO_FILL_RESET = 1'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [4:0] {
    BUS_IDLE = 5'h01,
    BUS_WACC = 5'h02,
    BUS_WRESP = 5'h04,
    BUS_RACC = 5'h08,
    BUS_RDATA = 5'h10
  } bus_state_type;

  typedef enum logic [2:0] {
    FAULT_NONE = 3'h0,
    FAULT_GP = 3'h1,
    FAULT_SS = 3'h2,
    FAULT_PF = 3'h3,
    FAULT_AC = 3'h4
  } fault_kind_type;

  typedef struct packed {
    logic [7:0] prefix;
    logic [7:0] opcode;
    logic size32;
    logic [7:0] immediate_count_byte;
    logic [7:0] count_register_low_byte;
    logic [31:0] dest;
    logic [31:0] src;
    logic dest_is_mem;
  } req_type;

  typedef struct packed {
    logic protected_mode;
    logic seg_writable;
    logic over_limit;
    logic null_selector;
    logic over_stack_limit;
    logic page_fail;
    logic [31:0] page_code;
    logic align_enable;
    logic [1:0] cpl;
    logic [1:0] ea_low;
  } mem_check_type;

  typedef struct packed {
    logic carry_flag;
    logic parity_flag;
    logic auxiliary_carry_flag;
    logic zero_flag;
    logic sign_flag;
    logic overflow_flag;
  } flags_type;

  typedef struct packed {
    logic [31:0] result;
    logic result_we;
    logic flags_we;
    flags_type flags;
  } answer_type;

  typedef struct packed {
    fault_kind_type kind;
    logic [31:0] code;
  } fault_type;

  // top bit of an operand of either size
  function automatic logic top_bit(input logic [31:0] v, input logic size32);
    return size32 ? v[31] : v[15];
  endfunction
endpackage
`default_nettype wire

// File: fault_check.sv
// Purpose: memory-destination fault screening for the shifter
// Assumes: segment and paging checks arrive as resolved levels
// Notes: one fault reported, highest priority first
`timescale 1ns/1ns
`default_nettype none
module fault_check (
  input wire dps_pkg::mem_check_type chk,
  input wire logic dest_is_mem,
  input wire logic size32,
  output dps_pkg::fault_type fault
);
  logic unaligned;

  // priority order: protection, stack, paging, alignment
  always_comb begin
    unaligned = size32 ? (chk.ea_low != 2'h0) : chk.ea_low[0];
    fault.kind = dps_pkg::FAULT_NONE;
    fault.code = 32'h0;
    if (dest_is_mem) begin
      if ((chk.protected_mode && (chk.null_selector || !chk.seg_writable)) || chk.over_limit) begin
        fault.kind = dps_pkg::FAULT_GP;
      end else if (chk.over_stack_limit) begin
        fault.kind = dps_pkg::FAULT_SS;
      end else if (chk.page_fail) begin
        fault.kind = dps_pkg::FAULT_PF;
        fault.code = chk.page_code;
      end else if (chk.align_enable && chk.cpl == dps_pkg::CPL_USER && unaligned) begin
        fault.kind = dps_pkg::FAULT_AC;
      end
    end
  end
endmodule // fault_check
`default_nettype wire

// File: funnel_core.sv
// Purpose: combinational funnel shifter for both directions and sizes
// Assumes: count already masked to five bits
// Notes: counts at or past the size still give a repeatable value
`timescale 1ns/1ns
`default_nettype none
module funnel_core (
  input wire logic [31:0] dest,
  input wire logic [31:0] src,
  input wire logic [4:0] count,
  input wire logic size32,
  input wire logic left,
  output logic [31:0] result,
  output logic carry
);
  logic [63:0] wide;
  logic [64:0] shifted;

  // one wide shift; the extra bit catches the last bit shifted out
  always_comb begin
    if (left) begin
      wide = size32 ? {dest, src} : {dest[15:0], src[15:0], 32'h0};
      shifted = {1'b0, wide} << count;
      result = size32 ? shifted[63:32] : {16'h0, shifted[63:48]};
      carry = shifted[64];
    end else begin
      wide = size32 ? {src, dest} : {32'h0, src[15:0], dest[15:0]};
      shifted = {wide, 1'b0} >> count;
      result = size32 ? shifted[32:1] : {16'h0, shifted[16:1]};
      carry = shifted[0];
    end
  end
endmodule // funnel_core
`default_nettype wire
